// ### dv/i2q_host_model.sv
// i2q_host_model: host issuing image accesses on the link clock.
// Assumes the shell answers every taken request with one ack pulse.
`timescale 1ns/10ps
`default_nettype none

module i2q_host_model
(
  // link clock
  input wire logic i_clk_link,
  // shell answer
  input wire logic i_busy,
  input wire logic i_ack,
  input wire logic [31:0] i_rdata,
  input wire logic i_fault,
  // request
  output logic o_req,
  output logic o_wr,
  output logic [31:0] o_addr,
  output logic [31:0] o_wdata
);
  initial
  begin
    o_req = 1'b0;
    o_wr = 1'b0;
    o_addr = 32'h0;
    o_wdata = 32'h0;
  end

  // one access outstanding; released address and data lines carry the inverse of the last value
  task automatic access(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic f, output logic ok);
    int n;
    ok = 1'b0;
    rd = 32'h0;
    f = 1'b0;
    n = 0;
    do @(posedge i_clk_link); while (i_busy !== 1'b0 && ++n < 64);
    @(negedge i_clk_link);
    o_req = 1'b1;
    o_wr = w;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk_link);
    o_req = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
    for (n = 0; n < 200 && !ok; n++)
    begin
      @(posedge i_clk_link);
      if (i_ack === 1'b1)
      begin
        ok = 1'b1;
        rd = i_rdata;
        f = i_fault;
      end
    end
  endtask
endmodule

`default_nettype wire

// ### dv/tb_top.sv
// tb_top: self-checking bench for the message shell.
// Assumes the host model drives the link side; local lists are modelled here.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end

module tb_top;
  logic i_clk_sys, i_rst_n, i_clk_link, i_rst_link_n, hreq, hwr, busy, ack, flt;
  logic en, ext, free_v, opost_v, frm_req, frm_wr, frm_ack, irq, flt_l;
  logic in_pop, in_push, out_pop, out_push;
  logic [31:0] haddr, hwdata, hrdata, oidx, iop_idx, frm_a, rd;
  logic [4:0] size_f;
  logic [11:0] idx_off;
  logic [0:31] free_d, ipd, opost_d, ofd, frm_wd, frm_rd, ipd_l, ofd_l, fwd_l;
  int mismatches, total_checks, n_ipop, n_ipush, n_opop, n_opush, n_frm, cyc, frm_cnt;

  i2q_shell i2q_shell_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_clk_link(i_clk_link), .i_rst_link_n(i_rst_link_n), .i_hst_req(hreq),
    .i_hst_wr(hwr), .i_hst_addr(haddr), .i_hst_wdata(hwdata), .o_hst_busy(busy),
    .o_hst_ack(ack), .o_hst_rdata(hrdata), .o_hst_fault(flt),
    .i_msg_unit_enable(en), .i_msg_ext_option_enable(ext), .i_image_size_field(size_f),
    .i_host_index_offset_reg(idx_off), .i_iop_outbound_index(iop_idx),
    .i_in_free_valid(free_v), .i_in_free_data(free_d), .o_in_free_pop(in_pop),
    .o_in_post_push(in_push), .o_in_post_data(ipd), .i_out_post_valid(opost_v),
    .i_out_post_data(opost_d), .o_out_post_pop(out_pop), .o_out_free_push(out_push),
    .o_out_free_data(ofd), .o_frm_req(frm_req), .o_frm_wr(frm_wr), .o_frm_addr(frm_a),
    .o_frm_wdata(frm_wd), .i_frm_ack(frm_ack), .i_frm_rdata(frm_rd),
    .o_host_outbound_index(oidx), .o_irq(irq));

  i2q_host_model i2q_host_model_inst (.i_clk_link(i_clk_link), .i_busy(busy),
    .i_ack(ack), .i_rdata(hrdata), .i_fault(flt), .o_req(hreq), .o_wr(hwr),
    .o_addr(haddr), .o_wdata(hwdata));

  initial
  begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  initial
  begin
    i_clk_link = 1'b0;
    #7;
    forever #62.5 i_clk_link = ~i_clk_link;
  end

  // local list and frame memory monitor, plus run ceiling
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      end_of_test();
    end
    n_ipop += int'(in_pop === 1'b1);
    n_opop += int'(out_pop === 1'b1);
    if (in_push === 1'b1)
    begin
      n_ipush++;
      ipd_l = ipd;
    end
    if (out_push === 1'b1)
    begin
      n_opush++;
      ofd_l = ofd;
    end
    if (frm_req === 1'b1)
    begin
      n_frm++;
      fwd_l = frm_wd;
      frm_cnt = frm_wr ? 0 : 3;
    end
  end

  always @(negedge i_clk_sys)
  begin
    frm_ack <= (frm_cnt == 1);
    frm_rd <= (frm_cnt == 1) ? 32'h5a5a_0c3c : 32'ha5a5_f3c3;
    if (frm_cnt != 0)
      frm_cnt--;
  end

  task automatic end_of_test();
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic hst(input logic w, input logic [31:0] a, input logic [31:0] d);
    logic ok;
    i2q_host_model_inst.access(w, a, d, rd, flt_l, ok);
    `CHK(ok, 1'b1)
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    hst(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  task automatic sys_wait(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask

  task automatic t_regs();
    rdchk(32'h030, 32'h0);
    rdchk(32'h034, 32'h0);
    `CHK(irq, 1'b0)
    hst(1'b1, 32'h034, 32'hffff_ffff);
    rdchk(32'h034, 32'h8);
    hst(1'b1, 32'h038, 32'hffff_ffff);
    rdchk(32'h038, 32'h0);
    rdchk(32'h000, 32'h0);
  endtask

  task automatic t_pend();
    sys_wait(1);
    opost_v = 1'b1;
    sys_wait(4);
    rdchk(32'h030, 32'h8);
    `CHK(irq, 1'b0)
    hst(1'b1, 32'h034, 32'h0);
    rdchk(32'h034, 32'h0);
    sys_wait(4);
    `CHK(irq, 1'b1)
    opost_v = 1'b0;
    sys_wait(4);
    `CHK(irq, 1'b0)
    rdchk(32'h030, 32'h0);
  endtask

  task automatic t_queues();
    sys_wait(1);
    free_v = 1'b1;
    rdchk(32'h040, 32'h0000_2040);
    `CHK(n_ipop, 1)
    sys_wait(1);
    free_v = 1'b0;
    rdchk(32'h040, 32'hffff_ffff);
    `CHK(n_ipop, 1)
    hst(1'b1, 32'h040, 32'h0000_3000);
    rdchk(32'h000, 32'h0);
    `CHK(n_ipush, 1)
    `CHK(ipd_l, 32'h0000_3000)
    sys_wait(1);
    opost_v = 1'b1;
    rdchk(32'h044, 32'h0000_4400);
    `CHK(n_opop, 1)
    sys_wait(1);
    opost_v = 1'b0;
    hst(1'b1, 32'h044, 32'h0000_5500);
    rdchk(32'h000, 32'h0);
    `CHK(n_opush, 1)
    `CHK(ofd_l, 32'h0000_5500)
  endtask

  task automatic t_frames();
    rdchk(32'h0ffc, 32'h0);
    `CHK(n_frm, 0)
    hst(1'b1, 32'h1000, 32'h1234_5678);
    rdchk(32'h000, 32'h0);
    `CHK(n_frm, 1)
    `CHK(frm_a, 32'h0000_1000)
    `CHK(frm_wr, 1'b1)
    `CHK(fwd_l, 32'h1234_5678)
    rdchk(32'h1ffc, 32'h5a5a_0c3c);
    `CHK(frm_a, 32'h0000_1ffc)
    `CHK(frm_wr, 1'b0)
    hst(1'b0, 32'h2000, 32'h0);
    `CHK(flt_l, 1'b1)
    `CHK(rd, 32'h0)
  endtask

  task automatic t_ext();
    sys_wait(1);
    ext = 1'b1;
    iop_idx = 32'h0000_0100;
    hst(1'b1, 32'h080, 32'h0000_0100);
    rdchk(32'h080, 32'h0000_0100);
    `CHK(oidx, 32'h0000_0100)
    sys_wait(4);
    rdchk(32'h030, 32'h0);
    sys_wait(1);
    iop_idx = 32'h0000_0104;
    sys_wait(4);
    rdchk(32'h030, 32'h8);
    hst(1'b1, 32'h084, 32'hffff_ffff);
    rdchk(32'h084, 32'h0);
    hst(1'b1, 32'h080, 32'h0000_0107);
    rdchk(32'h080, 32'h0000_0104);
    sys_wait(4);
    rdchk(32'h030, 32'h0);
    sys_wait(1);
    ext = 1'b0;
  endtask

  task automatic t_off();
    sys_wait(1);
    en = 1'b0;
    sys_wait(2);
    hst(1'b0, 32'h030, 32'h0);
    `CHK(flt_l, 1'b1)
    `CHK(rd, 32'h0)
    hst(1'b1, 32'h040, 32'h0000_6000);
    hst(1'b1, 32'h034, 32'hffff_ffff);
    rdchk(32'h034, 32'h0);
    `CHK(flt_l, 1'b1)
    `CHK(n_ipush, 1)
    sys_wait(1);
    en = 1'b1;
    rdchk(32'h034, 32'h0);
    `CHK(flt_l, 1'b0)
  endtask

  initial
  begin
    i_rst_n = 1'b0;
    i_rst_link_n = 1'b0;
    en = 1'b1;
    ext = 1'b0;
    size_f = 5'h01;
    idx_off = 12'h080;
    iop_idx = 32'h0;
    free_v = 1'b0;
    free_d = 32'h0000_2040;
    opost_v = 1'b0;
    opost_d = 32'h0000_4400;
    frm_ack = 1'b0;
    frm_rd = 32'h0;
    frm_cnt = 0;
    cyc = 0;
    mismatches = 0;
    total_checks = 0;
    sys_wait(8);
    i_rst_n = 1'b1;
    repeat (8) @(negedge i_clk_link);
    i_rst_link_n = 1'b1;
    repeat (2) @(negedge i_clk_link);
    t_regs();
    t_pend();
    t_queues();
    t_frames();
    t_ext();
    t_off();
    end_of_test();
  end
endmodule

`default_nettype wire

// ### hdl/i2q_link.sv
// i2q_link: host-facing end of the shell, on the link clock.
// Assumes the host waits for o_hst_busy low before a new request.
`timescale 1ns/10ps
`default_nettype none
`include "i2q_map.svh"

module i2q_link
(
  // link clock and reset
  input wire logic i_clk_link,
  input wire logic i_rst_link_n,
  // host request
  input wire logic i_hst_req,
  input wire logic i_hst_wr,
  input wire logic [31:0] i_hst_addr,
  input wire logic [31:0] i_hst_wdata,
  // host answer
  output logic o_hst_busy,
  output logic o_hst_ack,
  output logic [31:0] o_hst_rdata,
  output logic o_hst_fault,
  // crossing
  i2q_xing_if.link xing
);
  logic req_tgl_r, wr_r, a1_r, a2_r, a3_r, seen_r;
  logic [31:0] addr_r, wdata_r;
  wire logic take = i_hst_req && !o_hst_busy;
  wire logic ans_evt = (a2_r == a3_r) && (a3_r != seen_r);

  assign xing.req_tgl = req_tgl_r;
  assign xing.wr = wr_r;
  assign xing.addr = addr_r;
  assign xing.wdata = wdata_r;

  always_ff @(posedge i_clk_link)
  begin
    a1_r <= xing.ans_tgl;
    a2_r <= a1_r;
    a3_r <= a2_r;
    if (!i_rst_link_n)
    begin
      req_tgl_r <= `I2Q_RST_BIT;
      wr_r <= `I2Q_RST_BIT;
      addr_r <= `I2Q_RST_WORD;
      wdata_r <= `I2Q_RST_WORD;
      seen_r <= `I2Q_RST_BIT;
      o_hst_busy <= `I2Q_RST_BIT;
      o_hst_ack <= `I2Q_RST_BIT;
      o_hst_rdata <= `I2Q_RST_WORD;
      o_hst_fault <= `I2Q_RST_BIT;
    end
    else
    begin
      // posted writes are acknowledged at once, reads on the answer
      o_hst_ack <= (take && i_hst_wr) || (ans_evt && !wr_r);
      if (ans_evt)
        seen_r <= a3_r;
      if (take)
      begin
        req_tgl_r <= !req_tgl_r;
        wr_r <= i_hst_wr;
        addr_r <= i_hst_addr;
        wdata_r <= i_hst_wdata;
        o_hst_busy <= 1'b1;
        o_hst_rdata <= `I2Q_RST_WORD;
        o_hst_fault <= `I2Q_RST_BIT;
      end
      else if (ans_evt)
      begin
        o_hst_busy <= 1'b0;
        if (!wr_r)
        begin
          o_hst_rdata <= xing.rdata;
          o_hst_fault <= xing.fault;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ### hdl/i2q_map.svh
// i2q_map.svh: offsets, field positions, reset values and sizes of the message shell.
// Assumes it is included by its bare name from files under hdl/.
`ifndef I2Q_MAP_SVH
`define I2Q_MAP_SVH

// shell register offsets inside the image
`define I2Q_OFF_STATUS 12'h030
`define I2Q_OFF_MASK 12'h034
`define I2Q_OFF_INQ 12'h040
`define I2Q_OFF_OUTQ 12'h044
// window in which the relocatable index register may sit
`define I2Q_IDX_MIN 12'h048
`define I2Q_IDX_MAX 12'h0fc
// size of the shell window, frames start here
`define I2Q_SHELL_BYTES 32'h0000_1000
// field positions
`define I2Q_PEND_BIT 3
`define I2Q_MASK_BIT 3
`define I2Q_IDX_LSB 2
// value returned by a queue read when the list is empty
`define I2Q_EMPTY_WORD 32'hffff_ffff
// reset values
`define I2Q_RST_WORD 32'h0000_0000
`define I2Q_RST_BIT 1'b0

`endif

// ### hdl/i2q_pkg.sv
// i2q_pkg: types shared by the message shell modules.
// Assumes nothing of its surroundings.
`default_nettype none

package i2q_pkg;
  typedef enum logic [0:0] {
    i2q_st_idle = 1'b0,
    i2q_st_frame = 1'b1
  } i2q_state_t;
endpackage

`default_nettype wire

// ### hdl/i2q_shell.sv
// i2q_shell: message shell register window with inbound and outbound queue ports.
// Assumes local list sources, sinks and frame memory on i_clk_sys, host on i_clk_link.
`timescale 1ns/10ps
`default_nettype none
`include "i2q_map.svh"

module i2q_shell
  import i2q_pkg::*;
(
  // system clock and port reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // link clock and reset
  input wire logic i_clk_link,
  input wire logic i_rst_link_n,
  // host image access
  input wire logic i_hst_req,
  input wire logic i_hst_wr,
  input wire logic [31:0] i_hst_addr,
  input wire logic [31:0] i_hst_wdata,
  output logic o_hst_busy,
  output logic o_hst_ack,
  output logic [31:0] o_hst_rdata,
  output logic o_hst_fault,
  // unit control
  input wire logic i_msg_unit_enable,
  input wire logic i_msg_ext_option_enable,
  input wire logic [4:0] i_image_size_field,
  input wire logic [11:0] i_host_index_offset_reg,
  input wire logic [31:0] i_iop_outbound_index,
  // inbound free list source
  input wire logic i_in_free_valid,
  input wire logic [0:31] i_in_free_data,
  output logic o_in_free_pop,
  // inbound post list sink
  output logic o_in_post_push,
  output logic [0:31] o_in_post_data,
  // outbound post list source
  input wire logic i_out_post_valid,
  input wire logic [0:31] i_out_post_data,
  output logic o_out_post_pop,
  // outbound free list sink
  output logic o_out_free_push,
  output logic [0:31] o_out_free_data,
  // inbound frame memory
  output logic o_frm_req,
  output logic o_frm_wr,
  output logic [31:0] o_frm_addr,
  output logic [0:31] o_frm_wdata,
  input wire logic i_frm_ack,
  input wire logic [0:31] i_frm_rdata,
  // status
  output logic [31:0] o_host_outbound_index,
  output logic o_irq
);
  i2q_xing_if xing ();

  i2q_link u_link
  (
    .i_clk_link(i_clk_link),
    .i_rst_link_n(i_rst_link_n),
    .i_hst_req(i_hst_req),
    .i_hst_wr(i_hst_wr),
    .i_hst_addr(i_hst_addr),
    .i_hst_wdata(i_hst_wdata),
    .o_hst_busy(o_hst_busy),
    .o_hst_ack(o_hst_ack),
    .o_hst_rdata(o_hst_rdata),
    .o_hst_fault(o_hst_fault),
    .xing(xing)
  );

  // word match inside the shell window
  function automatic logic is_word(input logic [31:0] off, input logic [11:0] reg_off);
    is_word = (off < `I2Q_SHELL_BYTES) && (off[11:2] == reg_off[11:2]);
  endfunction

  i2q_state_t state_r, state_nxt;
  logic r1_r, r2_r, r3_r, seen_r;
  logic ans_tgl_r, fault_r, pending_r, mask_r;
  logic [31:0] rdata_r, host_idx_r;

  // request arrival from the link domain
  wire logic req_evt = (r2_r == r3_r) && (r3_r != seen_r);
  wire logic take = req_evt && (state_r == i2q_st_idle);
  wire logic [31:0] off = xing.addr;
  wire logic wr = xing.wr;
  wire logic en = i_msg_unit_enable;
  wire logic [31:0] img_bytes = `I2Q_SHELL_BYTES << i_image_size_field;

  // address decode
  wire logic in_shell = off < `I2Q_SHELL_BYTES;
  wire logic in_frame = !in_shell && (off < img_bytes);
  wire logic claim = en && (in_shell || in_frame);
  wire logic idx_ok = (i_host_index_offset_reg >= `I2Q_IDX_MIN)
    && (i_host_index_offset_reg <= `I2Q_IDX_MAX);
  wire logic hit_status = en && is_word(off, `I2Q_OFF_STATUS);
  wire logic hit_mask = en && is_word(off, `I2Q_OFF_MASK);
  wire logic hit_inq = en && is_word(off, `I2Q_OFF_INQ);
  wire logic hit_outq = en && is_word(off, `I2Q_OFF_OUTQ);
  wire logic hit_index = en && i_msg_ext_option_enable && idx_ok
    && is_word(off, i_host_index_offset_reg);
  wire logic frame_acc = claim && in_frame;
  wire logic frame_rd = take && frame_acc && !wr;

  // pending source and read data selection
  wire logic pending_nxt = i_msg_ext_option_enable
    ? (host_idx_r != i_iop_outbound_index) : i_out_post_valid;
  wire logic [31:0] status_word = 32'(pending_r) << `I2Q_PEND_BIT;
  wire logic [31:0] mask_word = 32'(mask_r) << `I2Q_MASK_BIT;
  wire logic [31:0] in_free_word = i_in_free_data;
  wire logic [31:0] out_post_word = i_out_post_data;
  wire logic [31:0] inq_word = i_in_free_valid ? in_free_word : `I2Q_EMPTY_WORD;
  wire logic [31:0] outq_word = i_out_post_valid ? out_post_word : `I2Q_EMPTY_WORD;
  wire logic [31:0] rd_word =
    hit_status ? status_word :
    hit_mask ? mask_word :
    hit_inq ? inq_word :
    hit_outq ? outq_word :
    hit_index ? host_idx_r :
    `I2Q_RST_WORD;

  assign xing.ans_tgl = ans_tgl_r;
  assign xing.rdata = rdata_r;
  assign xing.fault = fault_r;
  assign o_host_outbound_index = host_idx_r;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      i2q_st_idle:
        if (frame_rd)
          state_nxt = i2q_st_frame;
      i2q_st_frame:
        if (i_frm_ack)
          state_nxt = i2q_st_idle;
    endcase
  end

  // request toggle synchroniser
  always_ff @(posedge i_clk_sys)
  begin
    r1_r <= xing.req_tgl;
    r2_r <= r1_r;
    r3_r <= r2_r;
  end

  // handshake, state and answer
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      state_r <= i2q_st_idle;
      seen_r <= `I2Q_RST_BIT;
      ans_tgl_r <= `I2Q_RST_BIT;
      rdata_r <= `I2Q_RST_WORD;
      fault_r <= `I2Q_RST_BIT;
    end
    else
    begin
      state_r <= state_nxt;
      if (take)
      begin
        seen_r <= r3_r;
        fault_r <= !claim;
        rdata_r <= rd_word;
        if (!frame_rd)
          ans_tgl_r <= !ans_tgl_r;
      end
      else if (state_r == i2q_st_frame && i_frm_ack)
      begin
        rdata_r <= i_frm_rdata;
        ans_tgl_r <= !ans_tgl_r;
      end
    end
  end

  // shell registers and interrupt
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      pending_r <= `I2Q_RST_BIT;
      mask_r <= `I2Q_RST_BIT;
      host_idx_r <= `I2Q_RST_WORD;
      o_irq <= `I2Q_RST_BIT;
    end
    else
    begin
      pending_r <= pending_nxt;
      o_irq <= pending_r && !mask_r;
      if (take && wr && hit_mask)
        mask_r <= xing.wdata[`I2Q_MASK_BIT];
      if (take && wr && hit_index)
        host_idx_r <= {xing.wdata[31:`I2Q_IDX_LSB], 2'h0};
    end
  end

  // list pops and pushes
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_in_free_pop <= `I2Q_RST_BIT;
      o_out_post_pop <= `I2Q_RST_BIT;
      o_in_post_push <= `I2Q_RST_BIT;
      o_out_free_push <= `I2Q_RST_BIT;
      o_in_post_data <= `I2Q_RST_WORD;
      o_out_free_data <= `I2Q_RST_WORD;
    end
    else
    begin
      o_in_free_pop <= take && !wr && hit_inq && i_in_free_valid;
      o_out_post_pop <= take && !wr && hit_outq && i_out_post_valid;
      o_in_post_push <= take && wr && hit_inq;
      o_out_free_push <= take && wr && hit_outq;
      if (take && wr && hit_inq)
        o_in_post_data <= xing.wdata;
      if (take && wr && hit_outq)
        o_out_free_data <= xing.wdata;
    end
  end

  // frame memory forwarding
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_frm_req <= `I2Q_RST_BIT;
      o_frm_wr <= `I2Q_RST_BIT;
      o_frm_addr <= `I2Q_RST_WORD;
      o_frm_wdata <= `I2Q_RST_WORD;
    end
    else
    begin
      o_frm_req <= take && frame_acc;
      if (take && frame_acc)
      begin
        o_frm_wr <= wr;
        o_frm_addr <= off;
        o_frm_wdata <= xing.wdata;
      end
    end
  end

  // checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  a_irq_when_pending: assert property (pending_r && !mask_r |=> o_irq)
    else $error("interrupt not raised for unmasked pending");
  a_irq_masked: assert property (mask_r && $past(mask_r) |-> !o_irq)
    else $error("interrupt raised while masked");
  a_irq_idle: assert property (!pending_r |=> !o_irq)
    else $error("interrupt raised without pending");
  a_pend_empty: assert property (!i_msg_ext_option_enable
    && !i_out_post_valid |=> !pending_r)
    else $error("pending set with empty outbound post list");
  a_pend_full: assert property (!i_msg_ext_option_enable
    && i_out_post_valid && mask_r |=> pending_r)
    else $error("pending hidden by mask");
  a_pend_index: assert property (i_msg_ext_option_enable
    && (host_idx_r != i_iop_outbound_index) |=> pending_r)
    else $error("pending clear while indexes differ");
  a_pend_index_eq: assert property (i_msg_ext_option_enable
    && (host_idx_r == i_iop_outbound_index) |=> !pending_r)
    else $error("pending set while indexes match");
  a_mask_write: assert property (take && wr && hit_mask
    |=> mask_r == $past(xing.wdata[`I2Q_MASK_BIT]))
    else $error("mask write not stored");
  a_status_read: assert property (take && !wr && hit_status
    |=> rdata_r == (32'($past(pending_r)) << `I2Q_PEND_BIT))
    else $error("status read wrong");
  a_disabled_silent: assert property (take && !en
    |=> fault_r && !o_in_free_pop && !o_in_post_push && !o_frm_req)
    else $error("disabled unit responded");
  a_inq_pop: assert property (take && !wr && hit_inq && i_in_free_valid
    |=> o_in_free_pop ##1 !o_in_free_pop)
    else $error("inbound queue read did not pop once");
  a_inq_empty: assert property (take && !wr && hit_inq && !i_in_free_valid
    |=> !o_in_free_pop && rdata_r == `I2Q_EMPTY_WORD)
    else $error("empty inbound queue read wrong");
  a_inq_push: assert property (take && wr && hit_inq
    |=> o_in_post_push && o_in_post_data == $past(xing.wdata))
    else $error("inbound queue write not pushed");
  a_outq_pop: assert property (take && !wr && hit_outq && i_out_post_valid
    |=> o_out_post_pop)
    else $error("outbound queue read did not pop");
  a_outq_empty: assert property (take && !wr && hit_outq && !i_out_post_valid
    |=> !o_out_post_pop && rdata_r == `I2Q_EMPTY_WORD)
    else $error("empty outbound queue read wrong");
  a_outq_push: assert property (take && wr && hit_outq
    |=> o_out_free_push && o_out_free_data == $past(xing.wdata))
    else $error("outbound queue write not pushed");
  a_index_write: assert property (take && wr && hit_index
    |=> host_idx_r[31:2] == $past(xing.wdata[31:2]))
    else $error("host index write not stored");
  a_shell_no_frame: assert property (take && in_shell |=> !o_frm_req)
    else $error("shell access forwarded to frames");
  a_frame_fwd: assert property (take && frame_acc
    |=> o_frm_req && o_frm_addr == $past(off))
    else $error("frame access not forwarded");
  a_frame_answer: assert property (state_r == i2q_st_frame && i_frm_ack
    |=> state_r == i2q_st_idle && rdata_r == $past(i_frm_rdata))
    else $error("frame read answer lost");
  a_beyond_image: assert property (take && !in_shell && !in_frame
    |=> fault_r && !o_frm_req)
    else $error("access beyond image claimed");
  a_reserved_zero: assert property (take && !wr && claim && in_shell && !hit_status
    && !hit_mask && !hit_inq && !hit_outq && !hit_index |=> rdata_r == '0)
    else $error("reserved offset read nonzero");

  c_inq_read: cover property (take && !wr && hit_inq && i_in_free_valid);
  c_outq_write: cover property (take && wr && hit_outq);
  c_frame_read: cover property (state_r == i2q_st_frame && i_frm_ack);
  c_irq_rise: cover property (!o_irq ##1 o_irq);
  c_ext_pending: cover property (i_msg_ext_option_enable && pending_r);
endmodule

`default_nettype wire

// ### hdl/i2q_xing_if.sv
// i2q_xing_if: request and answer crossing between link and system clock domains.
// Assumes fields are held stable while their toggle is in flight.
`timescale 1ns/10ps
`default_nettype none

interface i2q_xing_if;
  logic req_tgl;
  logic wr;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic ans_tgl;
  logic [31:0] rdata;
  logic fault;
  modport link (output req_tgl, wr, addr, wdata, input ans_tgl, rdata, fault);
  modport core (input req_tgl, wr, addr, wdata, output ans_tgl, rdata, fault);
endinterface

`default_nettype wire
